// ---- core/pag_defines.svh ----
// Register offsets, field positions, reset values and timing figures
// for the parameter access guard; included by the core, the host model and the testbench.
`ifndef PAG_DEFINES_SVH
`define PAG_DEFINES_SVH

// Register offsets (byte addresses)
`define PAG_ADDR_STATUS 8'h00
`define PAG_ADDR_CTRL 8'h04
`define PAG_ADDR_PW_OEM 8'h08
`define PAG_ADDR_PW_INST 8'h0C
`define PAG_ADDR_PW_ENTER 8'h10
`define PAG_ADDR_IDLE 8'h14

// Status fields
`define PAG_ST_PRIV_LO 0
`define PAG_ST_PRIV_HI 2
`define PAG_ST_CONF 3
`define PAG_ST_PWFAIL 4

// Control fields
`define PAG_CTRL_EXIT 0
`define PAG_CTRL_CONFIRM 1

// Control block kinds
`define PAG_CB_ATTR 2'h0
`define PAG_CB_ALERT 2'h1
`define PAG_CB_RANGE 2'h2
`define PAG_CB_ENUM 2'h3

// Attribute entry fields
`define PAG_ATTR_HIDDEN 0
`define PAG_ATTR_RO 1
`define PAG_ATTR_PWL_LO 2
`define PAG_ATTR_PWL_HI 3
`define PAG_ATTR_SAFETY 4
`define PAG_ATTR_RANGE 5

// Alert entry fields
`define PAG_ALERT_EN 0
`define PAG_ALERT_ALARM 1

// Required password levels
`define PAG_PWL_NONE 2'h0
`define PAG_PWL_INST 2'h1
`define PAG_PWL_OEM 2'h2

// Enumerated selections that a mask can suppress
`define PAG_ENUM_W 16
`define PAG_ENUM_IDX_W 4

// Reset values
`define PAG_RST_ALERT_EN 1'h1
`define PAG_RST_ALARM 1'h0
`define PAG_RST_RANGE_ON 1'h1
`define PAG_RST_PW_OEM 32'h0000_5A01
`define PAG_RST_PW_INST 32'h0000_5A02

// Timing
`define PAG_CLK_KHZ 40000
`define PAG_TICK_MS 1
`define PAG_TIMEOUT_MIN 10
`define PAG_SEC_PER_MIN 60
`define PAG_MS_PER_SEC 1000

`endif

// ---- core/pag_guard.sv ----
// Parameter access guard: privilege, timeout, control blocks and write gating.
// Assumes one 40 MHz clock, synchronous inputs and one-cycle request strobes.
//
// Operation
// [RULE1] Power-up unconfigured: safety loads off, status says setup needed.
// [RULE2] Three privilege levels: OEM above installer above end user.
// [RULE3] Privilege holds until ten idle minutes pass or exit is commanded; a failed password entry also drops it to end user here.
// [RULE4] OEM may change OEM and installer items; installer only installer items.
// [RULE5] Attribute, alert setting and range limit blocks may be stored.
// [RULE6] Control blocks come over Modbus; refused unless OEM privilege.
// [RULE7] Attribute entry gives range limit, hidden, read-only and password level.
// [RULE8] A present range limit constrains the parameter's value.
// [RULE9] Password attribute selects OEM, installer or none before altering.
// [RULE10] Every parameter is readable over Modbus whatever its attributes.
// [RULE11] Modbus write to read-only or underprivileged item gets error response.
// [RULE12] Display: hidden items not shown nor writable; else read-only and password gate.
// [RULE13] Modbus: hidden ignored; password flag gates; read-only always refuses.
// [RULE14] Read-only parameters never change at any privilege.
// [RULE15] Disabled alerts are never presented.
// [RULE16] Enabled alerts close the alarm contact when their setting says so.
// [RULE17] Listed numeric parameters are held within stored minimum and maximum.
// [RULE18] Listed enumerated parameters reject suppressed selections.
// [RULE19] Unlisted parameters accept their whole native range.
// [RULE20] OEM replaces the default OEM and installer passwords.
// [RULE21] Safety items with no password still need installer privilege.
// [RULE22] Accepted edits restart the idle timer; expiry drops to end user at once.
// [RULE23] Permission decided combinationally; refused writes leave the value as is.
`timescale 1ns/1ps
`include "pag_defines.svh"

module pag_guard
	import pag_pkg::*;
#(
	parameter int IDX_W = 4,
	parameter int DATA_W = 16,
	parameter logic [15:0] TICK_CYCLES = 16'(`PAG_CLK_KHZ * `PAG_TICK_MS),
	parameter logic [19:0] TIMEOUT_TICKS =
		20'(`PAG_TIMEOUT_MIN * `PAG_SEC_PER_MIN * `PAG_MS_PER_SEC / `PAG_TICK_MS)
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic par_wr_i,
	input wire logic par_rd_i,
	input wire logic par_modbus_i,
	input wire logic [IDX_W-1:0] par_idx_i,
	input wire logic [DATA_W-1:0] par_wdata_i,
	output logic par_wr_done_o,
	output logic par_wr_err_o,
	output logic par_rd_done_o,
	output logic [DATA_W-1:0] par_rd_data_o,
	output logic par_rd_shown_o,
	input wire logic cb_wr_i,
	input wire logic [1:0] cb_kind_i,
	input wire logic [IDX_W-1:0] cb_idx_i,
	input wire logic [31:0] cb_data_i,
	output logic cb_done_o,
	output logic cb_err_o,
	input wire logic [(1<<IDX_W)-1:0] alert_i,
	output logic [(1<<IDX_W)-1:0] alert_shown_o,
	output logic alarm_contact_o,
	output logic loads_off_o,
	output logic setup_needed_o,
	output logic [2:0] priv_level_o
);

	localparam int NUM = 1 << IDX_W;

	typedef struct packed {
		pag_cfg_t cfg;
		pag_priv_t priv;
		logic [15:0] tick;
		logic [19:0] idle;
		logic [31:0] pw_oem;
		logic [31:0] pw_inst;
		logic pw_fail;
		logic [NUM-1:0] hid;
		logic [NUM-1:0] ro;
		logic [NUM-1:0][1:0] pwl;
		logic [NUM-1:0] safe;
		logic [NUM-1:0] rng_on;
		logic [NUM-1:0] aen;
		logic [NUM-1:0] aalm;
		logic [NUM-1:0] rlist;
		logic [NUM-1:0] renum;
		logic [NUM-1:0][DATA_W-1:0] rmin;
		logic [NUM-1:0][DATA_W-1:0] rmax;
		logic [NUM-1:0][`PAG_ENUM_W-1:0] rmask;
		logic [NUM-1:0][DATA_W-1:0] val;
		logic [31:0] rdata;
		logic wdone;
		logic werr;
		logic rdone;
		logic [DATA_W-1:0] rdat;
		logic rshown;
		logic cbdone;
		logic cberr;
		logic [NUM-1:0] ashown;
		logic alarm;
		logic loads_off;
		logic setup;
	} pag_state_t;

	pag_state_t s_r;
	pag_state_t s_nxt;
	logic tick_hit;
	logic wr_ok;
	logic expire;
	logic pw_try;
	logic ctrl_wr;

	// ==========================================================
	// Permission functions
	// [RULE4] privilege level ordering
	function automatic logic priv_meets(input pag_priv_t priv, input logic [1:0] need);
		logic ok;
		ok = 1'b0;
		case (priv)
			PAG_PRIV_OEM: ok = 1'b1;
			PAG_PRIV_INST: ok = (need != `PAG_PWL_OEM);
			PAG_PRIV_USER: ok = (need == `PAG_PWL_NONE);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	function automatic logic write_allowed(input logic modbus, input logic hidden, input logic ro,
		input logic safe, input logic [1:0] pwl, input pag_priv_t priv);
		logic [1:0] need;
		need = (safe && pwl == `PAG_PWL_NONE) ? `PAG_PWL_INST : pwl;
		return !ro && (modbus || !hidden) && priv_meets(priv, need);
	endfunction

	// [RULE17] [RULE18] limits and suppression
	function automatic logic range_ok(input logic listed, input logic is_enum,
		input logic [DATA_W-1:0] lo, input logic [DATA_W-1:0] hi,
		input logic [`PAG_ENUM_W-1:0] mask, input logic [DATA_W-1:0] d);
		logic ok;
		ok = 1'b1;
		if (listed && is_enum) begin
			ok = !(d < DATA_W'(`PAG_ENUM_W) && mask[d[`PAG_ENUM_IDX_W-1:0]]);
		end else if (listed) begin
			ok = (d >= lo) && (d <= hi);
		end
		return ok;
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.wdone = 1'b0;
		s_nxt.werr = 1'b0;
		s_nxt.rdone = 1'b0;
		s_nxt.cbdone = 1'b0;
		s_nxt.cberr = 1'b0;
		s_nxt.rdata = 32'h0000_0000;
		ctrl_wr = reg_wr_i && reg_addr_i == `PAG_ADDR_CTRL;
		pw_try = reg_wr_i && reg_addr_i == `PAG_ADDR_PW_ENTER;

		// [RULE9] [RULE21] [RULE23] combinational permission
		wr_ok = par_wr_i
			&& write_allowed(par_modbus_i, s_r.hid[par_idx_i], s_r.ro[par_idx_i], s_r.safe[par_idx_i],
				s_r.pwl[par_idx_i], s_r.priv)
			// [RULE8] [RULE19] range gate
			&& range_ok(s_r.rlist[par_idx_i] && s_r.rng_on[par_idx_i], s_r.renum[par_idx_i],
				s_r.rmin[par_idx_i], s_r.rmax[par_idx_i], s_r.rmask[par_idx_i], par_wdata_i);

		// Millisecond tick divider
		tick_hit = (s_r.tick == TICK_CYCLES - 16'h0001);
		s_nxt.tick = tick_hit ? 16'h0000 : s_r.tick + 16'h0001;

		// [RULE22] idle restart and expiry
		expire = tick_hit && s_r.priv != PAG_PRIV_USER && !wr_ok
			&& s_r.idle == TIMEOUT_TICKS - 20'h00001;
		if (s_r.priv == PAG_PRIV_USER || wr_ok || expire) begin
			s_nxt.idle = 20'h00000;
		end else if (tick_hit) begin
			s_nxt.idle = s_r.idle + 20'h00001;
		end

		// [RULE3] drop on timeout or exit
		if (expire || (ctrl_wr && reg_wdata_i[`PAG_CTRL_EXIT])) begin
			s_nxt.priv = PAG_PRIV_USER;
		end

		// [RULE2] password entry selects level
		if (pw_try) begin
			s_nxt.idle = 20'h00000;
			s_nxt.pw_fail = 1'b0;
			if (reg_wdata_i == s_r.pw_oem) begin
				s_nxt.priv = PAG_PRIV_OEM;
			end else if (reg_wdata_i == s_r.pw_inst) begin
				s_nxt.priv = PAG_PRIV_INST;
			end else begin
				s_nxt.priv = PAG_PRIV_USER;
				s_nxt.pw_fail = 1'b1;
			end
		end

		// [RULE20] password replacement at OEM level
		if (reg_wr_i && s_r.priv == PAG_PRIV_OEM) begin
			if (reg_addr_i == `PAG_ADDR_PW_OEM) begin
				s_nxt.pw_oem = reg_wdata_i;
			end
			if (reg_addr_i == `PAG_ADDR_PW_INST) begin
				s_nxt.pw_inst = reg_wdata_i;
			end
		end

		// [RULE1] configuration condition
		case (s_r.cfg)
			PAG_CFG_UNCONF: begin
				if (ctrl_wr && reg_wdata_i[`PAG_CTRL_CONFIRM] && s_r.priv != PAG_PRIV_USER) begin
					s_nxt.cfg = PAG_CFG_DONE;
				end
			end
			PAG_CFG_DONE: s_nxt.cfg = PAG_CFG_DONE;
			default: s_nxt.cfg = PAG_CFG_UNCONF;
		endcase
		s_nxt.loads_off = (s_nxt.cfg != PAG_CFG_DONE);
		s_nxt.setup = (s_nxt.cfg != PAG_CFG_DONE);

		// Register reads
		if (reg_rd_i) begin
			case (reg_addr_i)
				`PAG_ADDR_STATUS: begin
					s_nxt.rdata[`PAG_ST_PRIV_HI:`PAG_ST_PRIV_LO] = s_r.priv;
					s_nxt.rdata[`PAG_ST_CONF] = (s_r.cfg == PAG_CFG_DONE);
					s_nxt.rdata[`PAG_ST_PWFAIL] = s_r.pw_fail;
				end
				`PAG_ADDR_IDLE: s_nxt.rdata[19:0] = s_r.idle;
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// [RULE11] [RULE12] [RULE13] [RULE14] write answer
		if (par_wr_i) begin
			s_nxt.wdone = 1'b1;
			s_nxt.werr = !wr_ok;
			if (wr_ok) begin
				s_nxt.val[par_idx_i] = par_wdata_i;
			end
		end

		// [RULE10] reads are never refused
		if (par_rd_i) begin
			s_nxt.rdone = 1'b1;
			s_nxt.rdat = s_r.val[par_idx_i];
			s_nxt.rshown = par_modbus_i || !s_r.hid[par_idx_i];
		end

		// [RULE5] [RULE6] [RULE7] control block loading
		if (cb_wr_i) begin
			s_nxt.cbdone = 1'b1;
			s_nxt.cberr = (s_r.priv != PAG_PRIV_OEM);
			if (s_r.priv == PAG_PRIV_OEM) begin
				case (cb_kind_i)
					`PAG_CB_ATTR: begin
						s_nxt.hid[cb_idx_i] = cb_data_i[`PAG_ATTR_HIDDEN];
						s_nxt.ro[cb_idx_i] = cb_data_i[`PAG_ATTR_RO];
						s_nxt.pwl[cb_idx_i] = cb_data_i[`PAG_ATTR_PWL_HI:`PAG_ATTR_PWL_LO];
						s_nxt.safe[cb_idx_i] = cb_data_i[`PAG_ATTR_SAFETY];
						s_nxt.rng_on[cb_idx_i] = cb_data_i[`PAG_ATTR_RANGE];
					end
					`PAG_CB_ALERT: begin
						s_nxt.aen[cb_idx_i] = cb_data_i[`PAG_ALERT_EN];
						s_nxt.aalm[cb_idx_i] = cb_data_i[`PAG_ALERT_ALARM];
					end
					`PAG_CB_RANGE: begin
						s_nxt.rlist[cb_idx_i] = 1'b1;
						s_nxt.renum[cb_idx_i] = 1'b0;
						s_nxt.rmin[cb_idx_i] = cb_data_i[DATA_W-1:0];
						s_nxt.rmax[cb_idx_i] = cb_data_i[2*DATA_W-1:DATA_W];
					end
					`PAG_CB_ENUM: begin
						s_nxt.rlist[cb_idx_i] = 1'b1;
						s_nxt.renum[cb_idx_i] = 1'b1;
						s_nxt.rmask[cb_idx_i] = cb_data_i[`PAG_ENUM_W-1:0];
					end
					default: s_nxt.cberr = 1'b1;
				endcase
			end
		end

		// [RULE15] [RULE16] alert presentation and contact
		s_nxt.ashown = alert_i & s_r.aen;
		s_nxt.alarm = |(alert_i & s_r.aen & s_r.aalm);
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			s_r <= '0;
			s_r.cfg <= PAG_CFG_UNCONF;
			s_r.priv <= PAG_PRIV_USER;
			s_r.pw_oem <= `PAG_RST_PW_OEM;
			s_r.pw_inst <= `PAG_RST_PW_INST;
			s_r.aen <= {NUM{`PAG_RST_ALERT_EN}};
			s_r.aalm <= {NUM{`PAG_RST_ALARM}};
			s_r.rng_on <= {NUM{`PAG_RST_RANGE_ON}};
			s_r.loads_off <= 1'b1;
			s_r.setup <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata_o = s_r.rdata;
	assign par_wr_done_o = s_r.wdone;
	assign par_wr_err_o = s_r.werr;
	assign par_rd_done_o = s_r.rdone;
	assign par_rd_data_o = s_r.rdat;
	assign par_rd_shown_o = s_r.rshown;
	assign cb_done_o = s_r.cbdone;
	assign cb_err_o = s_r.cberr;
	assign alert_shown_o = s_r.ashown;
	assign alarm_contact_o = s_r.alarm;
	assign loads_off_o = s_r.loads_off;
	assign setup_needed_o = s_r.setup;
	assign priv_level_o = s_r.priv;

	// ==========================================================
	// Assertions
	default clocking cb_a @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	a_unconf_loads_off: assert property ( // [RULE1]
		s_r.cfg == PAG_CFG_UNCONF |-> loads_off_o && setup_needed_o)
		else $error("unconfigured but loads not held off");

	a_ro_never_written: assert property ( // [RULE14]
		par_wr_i && s_r.ro[par_idx_i] |=> par_wr_err_o && s_r.val[$past(par_idx_i)] == $past(s_r.val[par_idx_i]))
		else $error("read-only parameter changed");

	a_cb_needs_oem: assert property ( // [RULE6]
		cb_wr_i && s_r.priv != PAG_PRIV_OEM |=> cb_done_o && cb_err_o)
		else $error("control block taken without OEM privilege");

	a_hidden_display: assert property ( // [RULE12]
		par_wr_i && !par_modbus_i && s_r.hid[par_idx_i] |=> par_wr_done_o && par_wr_err_o)
		else $error("hidden parameter written from display");

	a_modbus_open: assert property ( // [RULE13]
		par_wr_i && par_modbus_i && !s_r.ro[par_idx_i] && s_r.pwl[par_idx_i] == `PAG_PWL_NONE
		&& !s_r.safe[par_idx_i] && !s_r.rlist[par_idx_i]
		|=> !par_wr_err_o ##0 s_r.val[$past(par_idx_i)] == $past(par_wdata_i))
		else $error("open parameter refused over Modbus");

	a_safety_install: assert property ( // [RULE21]
		par_wr_i && s_r.safe[par_idx_i] && s_r.priv == PAG_PRIV_USER |=> par_wr_err_o)
		else $error("safety parameter changed without privilege");

	a_inst_not_oem: assert property ( // [RULE4]
		par_wr_i && s_r.priv == PAG_PRIV_INST && s_r.pwl[par_idx_i] == `PAG_PWL_OEM |=> par_wr_err_o)
		else $error("installer changed an OEM parameter");

	a_timeout_drop: assert property ( // [RULE22]
		expire && !pw_try |=> priv_level_o == PAG_PRIV_USER && s_r.idle == 20'h00000)
		else $error("privilege kept after idle timeout");

	a_range_max: assert property ( // [RULE17]
		par_wr_i && s_r.rlist[par_idx_i] && s_r.rng_on[par_idx_i] && !s_r.renum[par_idx_i]
		&& par_wdata_i > s_r.rmax[par_idx_i] |=> par_wr_err_o)
		else $error("value above stored maximum accepted");

	a_alert_gate: assert property ( // [RULE15]
		1'b1 |=> (alert_shown_o & ~$past(s_r.aen)) == '0)
		else $error("disabled alert presented");

	a_read_open: assert property ( // [RULE10]
		par_rd_i && par_modbus_i |=> par_rd_done_o && par_rd_shown_o && par_rd_data_o == $past(s_r.val[par_idx_i]))
		else $error("Modbus read refused or wrong");

	c_timeout: cover property (expire);
	c_oem_load: cover property (cb_wr_i && s_r.priv == PAG_PRIV_OEM ##1 cb_done_o && !cb_err_o);
	c_modbus_err: cover property (par_wr_i && par_modbus_i ##1 par_wr_err_o);
	c_configured: cover property (s_r.cfg == PAG_CFG_UNCONF ##1 s_r.cfg == PAG_CFG_DONE);

endmodule

// ---- core/pag_pkg.sv ----
// Types shared by the parameter access guard.
// Assumes pag_defines.svh is on the include path.
package pag_pkg;

	// Privilege level, one-hot
	typedef enum logic [2:0] {
		PAG_PRIV_USER = 3'b001,
		PAG_PRIV_INST = 3'b010,
		PAG_PRIV_OEM = 3'b100
	} pag_priv_t;

	// Configuration condition, one-hot
	typedef enum logic [1:0] {
		PAG_CFG_UNCONF = 2'b01,
		PAG_CFG_DONE = 2'b10
	} pag_cfg_t;

endpackage

// ---- tb/pag_host_model.sv ----
// Host model: a display or Modbus master driving the guard's request ports.
// Assumes the guard answers each request one cycle after the edge that drives it.
`timescale 1ns/1ps
`include "pag_defines.svh"

module pag_host_model (
	input wire logic clk_sys_i,
	output logic [7:0] reg_addr_o,
	output logic [31:0] reg_wdata_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	input wire logic [31:0] reg_rdata_i,
	output logic par_wr_o,
	output logic par_rd_o,
	output logic par_modbus_o,
	output logic [3:0] par_idx_o,
	output logic [15:0] par_wdata_o,
	input wire logic par_wr_done_i,
	input wire logic par_wr_err_i,
	input wire logic par_rd_done_i,
	input wire logic [15:0] par_rd_data_i,
	input wire logic par_rd_shown_i,
	output logic cb_wr_o,
	output logic [1:0] cb_kind_o,
	output logic [3:0] cb_idx_o,
	output logic [31:0] cb_data_o,
	input wire logic cb_done_i,
	input wire logic cb_err_i
);
	initial begin
		{reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = '0;
		{par_wr_o, par_rd_o, par_modbus_o, par_idx_o, par_wdata_o} = '0;
		{cb_wr_o, cb_kind_o, cb_idx_o, cb_data_o} = '0;
	end

	// ==========================================
	// Bus cycles; released data lines go inverted
	task automatic reg_access(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys_i);
		reg_addr_o <= a;
		reg_wdata_o <= d;
		reg_wr_o <= wr;
		reg_rd_o <= ~wr;
		@(posedge clk_sys_i);
		reg_wr_o <= 1'b0;
		reg_rd_o <= 1'b0;
		reg_wdata_o <= ~d;
		#1;
		q = reg_rdata_i;
	endtask

	task automatic par_access(input logic wr, input logic mb, input logic [3:0] idx, input logic [15:0] d,
		output logic [19:0] r);
		@(posedge clk_sys_i);
		par_modbus_o <= mb;
		par_idx_o <= idx;
		par_wdata_o <= d;
		par_wr_o <= wr;
		par_rd_o <= ~wr;
		@(posedge clk_sys_i);
		par_wr_o <= 1'b0;
		par_rd_o <= 1'b0;
		par_wdata_o <= ~d;
		#1;
		r = wr ? {18'h0, par_wr_done_i, par_wr_err_i} : {2'h0, par_rd_done_i, par_rd_shown_i, par_rd_data_i};
	endtask

	task automatic cb_write(input logic [1:0] k, input logic [3:0] idx, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys_i);
		cb_kind_o <= k;
		cb_idx_o <= idx;
		cb_data_o <= d;
		cb_wr_o <= 1'b1;
		@(posedge clk_sys_i);
		cb_wr_o <= 1'b0;
		cb_data_o <= ~d;
		#1;
		r = {cb_done_i, cb_err_i};
	endtask

	task automatic set_passwords(input logic [31:0] oem, input logic [31:0] inst);
		logic [31:0] q;
		reg_access(1'b1, `PAG_ADDR_PW_OEM, oem, q);
		reg_access(1'b1, `PAG_ADDR_PW_INST, inst, q);
	endtask
endmodule

// ---- tb/tb_parameter_access_guard.sv ----
// Testbench for the parameter access guard: scenario tasks and closing report.
// Assumes the host model drives every request port; the bench drives alerts.
`timescale 1ns/1ps
`include "pag_defines.svh"

module tb_parameter_access_guard;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, cb_data_i, rw;
	logic reg_wr_i, reg_rd_i, par_wr_i, par_rd_i, par_modbus_i, cb_wr_i;
	logic [3:0] par_idx_i, cb_idx_i;
	logic [15:0] par_wdata_i, par_rd_data_o, alert_shown_o;
	logic [15:0] alert_i = 16'h0000;
	logic par_wr_done_o, par_wr_err_o, par_rd_done_o, par_rd_shown_o, cb_done_o, cb_err_o;
	logic alarm_contact_o, loads_off_o, setup_needed_o;
	logic [1:0] cb_kind_i, r2;
	logic [2:0] priv_level_o;
	logic [19:0] rr;
	int n_fail = 0;
	int checks_done = 0;
	int cyc = 0;

	always #12.5 clk_sys_i = ~clk_sys_i;

	pag_guard #(.TICK_CYCLES(16'h0010), .TIMEOUT_TICKS(20'h00005)) u_dut (
		.clk_sys_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.par_wr_i, .par_rd_i, .par_modbus_i, .par_idx_i, .par_wdata_i, .par_wr_done_o, .par_wr_err_o,
		.par_rd_done_o, .par_rd_data_o, .par_rd_shown_o, .cb_wr_i, .cb_kind_i, .cb_idx_i, .cb_data_i,
		.cb_done_o, .cb_err_o, .alert_i, .alert_shown_o, .alarm_contact_o, .loads_off_o,
		.setup_needed_o, .priv_level_o
	);

	pag_host_model u_host (
		.clk_sys_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i),
		.reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o), .par_wr_o(par_wr_i), .par_rd_o(par_rd_i),
		.par_modbus_o(par_modbus_i), .par_idx_o(par_idx_i), .par_wdata_o(par_wdata_i),
		.par_wr_done_i(par_wr_done_o), .par_wr_err_i(par_wr_err_o), .par_rd_done_i(par_rd_done_o),
		.par_rd_data_i(par_rd_data_o), .par_rd_shown_i(par_rd_shown_o), .cb_wr_o(cb_wr_i),
		.cb_kind_o(cb_kind_i), .cb_idx_o(cb_idx_i), .cb_data_o(cb_data_i), .cb_done_i(cb_done_o),
		.cb_err_i(cb_err_o)
	);

	// ==========================================
	// Compare and helper tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic mb, input logic [3:0] idx, input logic [15:0] d, input logic err);
		u_host.par_access(1'b1, mb, idx, d, rr);
		chk(32'(rr), 32'({1'b1, err}));
	endtask

	task automatic rd(input logic mb, input logic [3:0] idx, input logic shown, input logic [15:0] d);
		u_host.par_access(1'b0, mb, idx, 16'h0000, rr);
		chk(32'(rr), 32'({1'b1, shown, d}));
	endtask

	task automatic cb(input logic [1:0] k, input logic [3:0] idx, input logic [31:0] d, input logic err);
		u_host.cb_write(k, idx, d, r2);
		chk(32'(r2), 32'({1'b1, err}));
	endtask

	task automatic reg_op(input logic [7:0] a, input logic [31:0] d, input logic [2:0] exp);
		u_host.reg_access(1'b1, a, d, rw);
		chk(32'(priv_level_o), 32'(exp));
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset;
		chk(32'({loads_off_o, setup_needed_o, priv_level_o}), 32'h00000019);
		u_host.reg_access(1'b0, `PAG_ADDR_STATUS, 32'h00000000, rw);
		chk(rw, 32'h00000001);
	endtask

	task automatic t_user;
		cb(`PAG_CB_ATTR, 4'h1, 32'h00000002, 1'b1);
		wr(1'b1, 4'h0, 16'hFFFF, 1'b0);
		rd(1'b1, 4'h0, 1'b1, 16'hFFFF);
		reg_op(`PAG_ADDR_CTRL, 32'h00000002, 3'h1);
		chk(32'(setup_needed_o), 32'h00000001);
	endtask

	task automatic t_oem;
		reg_op(`PAG_ADDR_PW_ENTER, 32'h00005A01, 3'h4);
		u_host.set_passwords(32'h00001111, 32'h00002222);
		reg_op(`PAG_ADDR_PW_ENTER, 32'h00005A01, 3'h1);
		u_host.reg_access(1'b0, `PAG_ADDR_STATUS, 32'h00000000, rw);
		chk(rw, 32'h00000011);
		reg_op(`PAG_ADDR_PW_ENTER, 32'h00001111, 3'h4);
		cb(`PAG_CB_ATTR, 4'h1, 32'h00000002, 1'b0);
		cb(`PAG_CB_ATTR, 4'h2, 32'h00000004, 1'b0);
		cb(`PAG_CB_ATTR, 4'h3, 32'h00000008, 1'b0);
		cb(`PAG_CB_ATTR, 4'h4, 32'h00000001, 1'b0);
		cb(`PAG_CB_ATTR, 4'h5, 32'h00000010, 1'b0);
		cb(`PAG_CB_RANGE, 4'h6, 32'h0014000A, 1'b0);
		cb(`PAG_CB_ENUM, 4'h7, 32'h00000008, 1'b0);
		cb(`PAG_CB_ALERT, 4'h1, 32'h00000000, 1'b0);
		cb(`PAG_CB_ALERT, 4'h2, 32'h00000003, 1'b0);
	endtask

	task automatic t_gating;
		wr(1'b1, 4'h1, 16'h0005, 1'b1);
		rd(1'b1, 4'h1, 1'b1, 16'h0000);
		wr(1'b1, 4'h2, 16'h0007, 1'b0);
		wr(1'b1, 4'h3, 16'h0007, 1'b0);
		wr(1'b0, 4'h4, 16'h0007, 1'b1);
		rd(1'b0, 4'h4, 1'b0, 16'h0000);
		wr(1'b1, 4'h4, 16'h0007, 1'b0);
		wr(1'b0, 4'h2, 16'h0009, 1'b0);
		wr(1'b1, 4'h6, 16'h0015, 1'b1);
		wr(1'b1, 4'h6, 16'h0014, 1'b0);
		wr(1'b1, 4'h6, 16'h0009, 1'b1);
		wr(1'b1, 4'h6, 16'h000A, 1'b0);
		wr(1'b1, 4'h7, 16'h0003, 1'b1);
		wr(1'b1, 4'h7, 16'h0004, 1'b0);
	endtask

	task automatic t_installer;
		reg_op(`PAG_ADDR_PW_ENTER, 32'h00002222, 3'h2);
		wr(1'b1, 4'h3, 16'h0001, 1'b1);
		wr(1'b1, 4'h2, 16'h0001, 1'b0);
		wr(1'b1, 4'h5, 16'h0001, 1'b0);
		reg_op(`PAG_ADDR_CTRL, 32'h00000002, 3'h2);
		chk(32'({loads_off_o, setup_needed_o}), 32'h00000000);
		reg_op(`PAG_ADDR_CTRL, 32'h00000001, 3'h1);
		wr(1'b1, 4'h2, 16'h0002, 1'b1);
		wr(1'b1, 4'h5, 16'h0002, 1'b1);
		wr(1'b1, 4'h0, 16'h0003, 1'b0);
	endtask

	task automatic t_alerts;
		@(posedge clk_sys_i);
		alert_i <= 16'h0006;
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk(32'({alarm_contact_o, alert_shown_o}), 32'h00010004);
		@(posedge clk_sys_i);
		alert_i <= 16'h0001;
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk(32'({alarm_contact_o, alert_shown_o}), 32'h00000001);
		@(posedge clk_sys_i);
		alert_i <= 16'h0000;
	endtask

	task automatic t_timeout;
		reg_op(`PAG_ADDR_PW_ENTER, 32'h00001111, 3'h4);
		// Three ticks pass whatever the tick phase
		repeat (47) @(posedge clk_sys_i);
		u_host.reg_access(1'b0, `PAG_ADDR_IDLE, 32'h00000000, rw);
		chk(rw, 32'h00000003);
		wr(1'b1, 4'h0, 16'h0001, 1'b0);
		repeat (40) @(posedge clk_sys_i);
		#1;
		chk(32'(priv_level_o), 32'h00000004);
		repeat (90) @(posedge clk_sys_i);
		#1;
		chk(32'(priv_level_o), 32'h00000001);
	endtask

	// ==========================================
	// Report, sequence and hang limit
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		#1;
		t_reset();
		t_user();
		t_oem();
		t_gating();
		t_alerts();
		t_installer();
		t_timeout();
		complete_run();
	end

	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			complete_run();
		end
	end
endmodule
